// ---- core/ilo_decode.sv ----
// Operand address and execute logic for three byte and bit instructions.
// Covers indexed add to accumulator or file, indexed bit set and indexed fill.
// Assumes data memory read is combinational from rdAddr and write is taken on the clock.
// Assumes the fuse and the pointer come from logic on the core clock.
`timescale 1ns/100ps
`default_nettype none
module ilo_decode
    import ilo_pkg::*;
(
    input wire logic clk_sys, // Core instruction clock
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic extensionEnableFuse, // Extension configuration bit
    input wire logic instrValid, // Instruction word present this cycle
    input wire logic [15:0] instrWord, // Instruction word
    input wire logic [11:0] indirectPointerTwo, // Pointer two value
    input wire logic [3:0] bankSelectReg, // Bank select register
    input wire logic [7:0] rdData, // Byte at rdAddr
    input wire logic [4:0] statusIn, // Current status flags
    output logic [11:0] rdAddr, // Operand address
    output ilo_wr_t memWr, // Registered memory write
    output logic [7:0] accum_q, // Accumulator
    output logic [4:0] status_q, // Status flags
    output logic statusWe_q, // Status flags updated last cycle
    output logic indexedMode // Current operand is indexed
);
    // True when an operand byte lies inside the indexed window
    function automatic logic inOffsetWindow(input logic [7:0] f);
        logic r;
        r = (f <= OFFSET_MAX);
        return r;
    endfunction : inOffsetWindow

    // Forms the 12-bit operand address
    function automatic logic [11:0] effAddr(input logic ext, input logic a,
        input logic [7:0] f, input logic [11:0] ptr, input logic [3:0] bank);
        logic [11:0] r;
        r = {4'h0, f};
        if (ext && !a && inOffsetWindow(f)) begin
            r = ptr + {4'h0, f};
        end else if (a) begin
            r = {bank, f};
        end else if (f >= ACCESS_SPLIT) begin
            r = {ACCESS_HIGH_BANK, f};
        end else begin
            r = {4'h0, f};
        end
        return r;
    endfunction : effAddr

    // Flags of an 8-bit add, packed as {N, OV, Z, DC, C}
    function automatic logic [4:0] addFlagsOf(input logic [7:0] x, input logic [7:0] y);
        logic [8:0] s;
        logic [4:0] h;
        logic [4:0] fl;
        s = {1'b0, x} + {1'b0, y};
        h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
        fl = '0;
        fl[FLAG_C] = s[8];
        fl[FLAG_DC] = h[4];
        fl[FLAG_Z] = (s[7:0] == 8'h00);
        fl[FLAG_OV] = (x[7] == y[7]) && (s[7] != x[7]);
        fl[FLAG_N] = s[7];
        return fl;
    endfunction : addFlagsOf

    // One-hot mask for the selected bit
    function automatic logic [7:0] bitMask(input logic [2:0] b);
        logic [7:0] m;
        m = 8'h01 << b;
        return m;
    endfunction : bitMask

    // Fields of the instruction word
    logic [7:0] fileOperand;
    logic accessSel;
    logic destSel;
    logic [2:0] bitSel;
    logic [5:0] opHigh6;
    logic [3:0] opHigh4;
    logic [7:0] opHigh8;

    // Decode and address
    logic indexedNow;
    ilo_op_t op;
    logic [11:0] opAddr;

    // Add datapath
    logic [8:0] sum;
    logic [4:0] addFlags;

    // Next values of the state
    logic [7:0] accum_d;
    logic [4:0] status_d;
    logic statusWe_d;
    ilo_wr_t memWr_d;

    // Split the instruction word into its fields
    assign fileOperand = instrWord[7:0];
    assign accessSel = instrWord[ACCESS_BIT];
    assign destSel = instrWord[DEST_BIT];
    assign bitSel = instrWord[BITSEL_LO +: 3];
    assign opHigh6 = instrWord[15:10];
    assign opHigh4 = instrWord[15:12];
    assign opHigh8 = instrWord[15:8];

    // Indexed form needs the fuse, a clear access bit and an operand in the window
    always_comb begin
        indexedNow = extensionEnableFuse && !accessSel && inOffsetWindow(fileOperand);
    end

    // Opcode decode; nothing is taken unless the fuse is set and the operand is indexed
    always_comb begin
        op = ILO_OP_NONE;
        if (instrValid && indexedNow) begin
            if (opHigh6 == OPC_ADD) begin
                op = ILO_OP_ADD;
            end else if (opHigh4 == OPC_BSET) begin
                op = ILO_OP_BSET;
            end else if (opHigh8 == OPC_FILL) begin
                op = ILO_OP_FILL;
            end else begin
                op = ILO_OP_NONE;
            end
        end
    end

    // Operand address, shown to data memory in the same cycle
    always_comb begin
        opAddr = effAddr(extensionEnableFuse, accessSel, fileOperand, indirectPointerTwo,
            bankSelectReg);
    end

    // Combinational outputs
    assign rdAddr = opAddr;
    assign indexedMode = indexedNow;

    // Sum and flags of the indexed add
    always_comb begin
        sum = {1'b0, accum_q} + {1'b0, rdData};
        addFlags = addFlagsOf(accum_q, rdData);
    end

    // Accumulator next value: only an add with the destination bit clear writes it
    always_comb begin
        accum_d = accum_q;
        if (op == ILO_OP_ADD && !destSel) begin
            accum_d = sum[7:0];
        end
    end

    // Accumulator register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            accum_q <= ACCUM_RESET;
        end else begin
            accum_q <= accum_d;
        end
    end

    // Flags follow an add; bit set, fill and refused cycles pass the current flags through
    always_comb begin
        status_d = statusIn;
        statusWe_d = 1'b0;
        if (op == ILO_OP_ADD) begin
            status_d = addFlags;
            statusWe_d = 1'b1;
        end
    end

    // Flag registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= STATUS_RESET;
            statusWe_q <= 1'b0;
        end else begin
            status_q <= status_d;
            statusWe_q <= statusWe_d;
        end
    end

    // Write request; address and data stay zero on cycles without a write
    always_comb begin
        memWr_d = '0;
        case (op)
            ILO_OP_ADD: begin
                if (destSel) begin
                    memWr_d.en = 1'b1;
                    memWr_d.addr = opAddr;
                    memWr_d.data = sum[7:0];
                end
            end
            ILO_OP_BSET: begin
                memWr_d.en = 1'b1;
                memWr_d.addr = opAddr;
                memWr_d.data = rdData | bitMask(bitSel);
            end
            ILO_OP_FILL: begin
                memWr_d.en = 1'b1;
                memWr_d.addr = opAddr;
                memWr_d.data = FILL_VALUE;
            end
            default: begin
                memWr_d = '0;
            end
        endcase
    end

    // Write request register, a one-cycle pulse per write
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            memWr <= '0;
        end else begin
            memWr <= memWr_d;
        end
    end
endmodule : ilo_decode
`default_nettype wire

// ---- core/ilo_pkg.sv ----
// Package for the indexed literal offset decode and execute block.
// Assumes a core that fetches one 16-bit word per instruction cycle.
// Overview of operation
// - With extension on, access operands up to 5Fh are offsets from pointer two.
// - Indexed form only when access bit is zero; otherwise bank register or access bank.
// - Extension fuse one enables extended behaviour; zero disables it entirely.
// - Indexed add 0010 01d0 kkkk kkkk adds accumulator to byte, one cycle.
// - Add destination bit zero writes accumulator, one writes the data byte.
// - Indexed add updates negative, overflow, carry, digit carry and zero flags.
// - Bit set 1000 bbb0 kkkk kkkk sets chosen bit, flags unchanged.
// - Fill 0110 1000 kkkk kkkk writes FFh to the byte, flags unchanged.
package ilo_pkg;
    localparam int ADDR_W = 12;
    localparam logic [7:0] OFFSET_MAX = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [5:0] OPC_ADD = 6'b0010_01;
    localparam logic [3:0] OPC_BSET = 4'b1000;
    localparam logic [7:0] OPC_FILL = 8'b0110_1000;
    localparam logic [7:0] FILL_VALUE = 8'hFF;
    localparam logic [7:0] ACCUM_RESET = 8'h00;
    localparam logic [4:0] STATUS_RESET = 5'h00;
    localparam int ACCESS_BIT = 8;
    localparam int DEST_BIT = 9;
    localparam int BITSEL_LO = 9;
    localparam int FLAG_N = 4;
    localparam int FLAG_OV = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_DC = 1;
    localparam int FLAG_C = 0;

    // Decoded operation
    typedef enum logic [1:0] {
        ILO_OP_NONE = 2'b00,
        ILO_OP_ADD = 2'b01,
        ILO_OP_BSET = 2'b10,
        ILO_OP_FILL = 2'b11
    } ilo_op_t;

    // Data memory write request
    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } ilo_wr_t;
endpackage : ilo_pkg

// ---- dv/ilo_chk_assertions.sv ----
// Port checker for ilo_decode.
// Assumes one clock domain and combinational read data.
`timescale 1ns/100ps
`default_nettype none
module ilo_chk import ilo_pkg::*; (
    input wire logic clk_sys, reset_n, extensionEnableFuse, instrValid, // Clock, reset, controls
    input wire logic [15:0] instrWord, // Instruction
    input wire logic [11:0] indirectPointerTwo, rdAddr, // Pointer, address
    input wire logic [7:0] rdData, accum_q, // Read byte, accumulator
    input wire logic [4:0] statusIn, status_q, // Flags
    input wire ilo_wr_t memWr, // Write
    input wire logic statusWe_q, indexedMode // Flag strobe, indexed
);
    // Taken instruction and its sum
    wire logic go = instrValid && indexedMode;
    wire logic [7:0] sum = accum_q + rdData;
    wire logic cy = sum < accum_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_idx_mode: assert property (indexedMode == (extensionEnableFuse && !instrWord[8]
        && instrWord[7:0] <= OFFSET_MAX)) else $error("mode");
    a_idx_addr: assert property (indexedMode |->
        rdAddr == indirectPointerTwo + instrWord[7:0]) else $error("addr");
    a_add_acc: assert property (go && instrWord[15:9] == {OPC_ADD, 1'b0} |=>
        accum_q == $past(sum) && !memWr.en && statusWe_q) else $error("add acc");
    a_add_file: assert property (go && instrWord[15:9] == {OPC_ADD, 1'b1} |=> memWr.en
        && memWr.data == $past(sum) && memWr.addr == $past(rdAddr)) else $error("add file");
    a_add_flags: assert property (go && instrWord[15:10] == OPC_ADD |=>
        status_q[FLAG_C] == $past(cy) && status_q[FLAG_Z] == ($past(sum) == 8'h00)
        && status_q[FLAG_N] == $past(sum[7])) else $error("flags");
    a_bit_set: assert property (go && instrWord[15:12] == OPC_BSET |=>
        memWr.en && !statusWe_q
        && memWr.data == ($past(rdData) | (8'h01 << $past(instrWord[11:9]))))
        else $error("bset");
    a_fill_ones: assert property (go && instrWord[15:8] == OPC_FILL |=> memWr.en
        && memWr.data == FILL_VALUE && status_q == $past(statusIn)) else $error("fill");
    a_refused_op: assert property (!go |=> !memWr.en && !statusWe_q && $stable(accum_q))
        else $error("refused");
endmodule : ilo_chk
bind ilo_decode ilo_chk u_chk (.*);
`default_nettype wire

// ---- dv/tb_top.sv ----
// Random bench for ilo_decode against a reference model.
// Assumes the bench stands in for data memory.
`timescale 1ns/100ps
`default_nettype none
module tb_top import ilo_pkg::*;;
    logic clk_sys = 0, reset_n = 0, fu = 0, v = 0, swe, im;
    logic [15:0] w = 0, t;
    logic [11:0] p = 0, ra, r;
    logic [7:0] rd = 0, a = 0, acc, s;
    logic [3:0] bs = 0;
    logic [4:0] st = 0, sq;
    logic [39:0] e = 0;
    ilo_wr_t wr;
    int num_errors = 0, checks = 0;
    ilo_decode dut (.clk_sys, .reset_n, .extensionEnableFuse(fu), .instrValid(v), .instrWord(w),
        .indirectPointerTwo(p), .bankSelectReg(bs), .rdData(rd), .statusIn(st), .rdAddr(ra),
        .memWr(wr), .accum_q(acc), .status_q(sq), .statusWe_q(swe), .indexedMode(im));
    initial forever #25 clk_sys = ~clk_sys;
    // Compare and count
    task automatic chk(input logic [39:0] g, x);
        checks++;
        if (g !== x) begin
            num_errors++;
            $display("Error %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // Random instructions, mostly indexed; address and mode checked in the same cycle, results one cycle later
    initial begin
        void'($urandom(32'h7ebf));
        repeat (3) @(posedge clk_sys);
        reset_n <= 1;
        repeat (600) begin
            @(posedge clk_sys);
            t = 16'($urandom);
            case ($urandom % 4)
                0: t[15:10] = OPC_ADD;
                1: t[15:12] = OPC_BSET;
                2: t[15:8] = OPC_FILL;
                default: ;
            endcase
            if ($urandom % 4) t[8:0] = {$urandom % 5 == 0, t[7:0] % 8'h60};
            w <= t;
            fu <= $urandom % 8 != 0;
            v <= $urandom % 8 != 0;
            {p, rd, st, bs} <= 29'($urandom);
            #1;
            chk({5'h0, wr, acc, sq, swe}, e);
            if (fu && !w[8] && w[7:0] <= OFFSET_MAX) r = p + w[7:0];
            else if (w[8]) r = {bs, w[7:0]};
            else r = {w[7:0] < 8'h60 ? 4'h0 : ACCESS_HIGH_BANK, w[7:0]};
            chk({27'h0, ra, im}, {27'h0, r, fu && !w[8] && w[7:0] <= OFFSET_MAX});
            s = a + rd;
            e = {34'h0, st, 1'b0};
            if (v && fu && !w[8] && w[7:0] <= OFFSET_MAX) begin
                if (w[15:10] == OPC_ADD) begin
                    e[5:0] = {s[7], a[7] == rd[7] && s[7] != a[7], s == 0,
                        a[3:0] + rd[3:0] > 15, s < a, 1'b1};
                    if (w[9]) e[34:14] = {1'b1, p + w[7:0], s};
                    else a = s;
                end else if (w[15:12] == OPC_BSET) e[34:14] = {1'b1, p + w[7:0], rd | 8'h01 << w[11:9]};
                else if (w[15:8] == OPC_FILL) e[34:14] = {1'b1, p + w[7:0], FILL_VALUE};
            end
            e[13:6] = a;
        end
        $display("random test done");
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
